// [rtl/csrb_bank.sv]
/*
 register bank of the clock synchronizer: byte registers, sticky event
 flags, interrupt output and the multi-byte frame phase offset.
 assumes the serial front end presents one-cycle rd/wr strobes with a
 7-bit address and 8-bit data, and reads rdata in the cycle after rd.
*/
// Overview of operation
// - int_n low while any unmasked ref failure or loop event sticky bit set
// - reference failure and mode change are events
// - sticky bits hold after condition clears
// - reading sticky register clears its bits
// - all accesses are single bytes
// - read snapshot holds until next low byte read
// - write buffered, committed on high byte
// - 22-bit phase offset at 0x40..0x42
// - address 0x00 returns chip identification
// - event masks at 0x09 and 0x0A gate interrupt
// - monitor failures at 0x05, 0x0C masks ref failure capture
// - 0x21 masks failures from triggering holdover
// - 0x28 reports lock and holdover status
// - 0x10 reports detected input frequency
// - 0x1D selects loop filter bandwidth
// - 7-bit address and 8-bit data
`timescale 1ns/1ns
module csrb_bank (
    input wire logic clk,
    input wire logic reset,
    input wire csrb_pkg::csrb_req_t req,
    input wire csrb_pkg::csrb_stat_t stat,
    output logic [7:0] rdata,
    output logic int_n,
    output logic [7:0] loop_bandwidth,
    output logic [7:0] holdover_trigger_mask,
    output logic holdover_trigger,
    output logic [21:0] frame_phase_offset
);
    logic [7:0] ref_fail_mask;
    logic [7:0] loop_mask;
    logic [7:0] mon_fail_mask;
    logic [7:0] loop_events;
    logic [7:0] mon_fail_sticky;
    logic [7:0] ref_fail_sticky;
    logic locked_d;
    logic holdover_d;
    logic [7:0] wbuf_low;
    logic [7:0] wbuf_mid;
    logic [21:0] rsnap;
    logic [7:0] next_rdata;
    logic [7:0] next_loop_events;
    logic [7:0] next_mon_fail;
    logic [7:0] next_ref_fail;
    logic rd_loop;
    logic rd_mon;
    logic rd_ref;

    assign rd_loop = req.rd && (req.addr == csrb_pkg::ADDR_LOOP_EVENT);
    assign rd_mon = req.rd && (req.addr == csrb_pkg::ADDR_REF_MON_FAIL);
    assign rd_ref = req.rd && (req.addr == csrb_pkg::ADDR_REF_FAIL_EVENT);

    // mode change edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            locked_d <= 1'b0;
            holdover_d <= 1'b0;
        end else begin
            locked_d <= stat.locked;
            holdover_d <= stat.holdover;
        end
    end

    // sticky event flags, set wins over read clear
    always_comb begin
        next_loop_events = rd_loop ? 8'h00 : loop_events;
        next_loop_events[csrb_pkg::LOOP_EV_LOCK] = next_loop_events[csrb_pkg::LOOP_EV_LOCK]
            | (stat.locked ^ locked_d);
        next_loop_events[csrb_pkg::LOOP_EV_HOLDOVER] =
            next_loop_events[csrb_pkg::LOOP_EV_HOLDOVER]
            | (stat.holdover ^ holdover_d);
        next_mon_fail = (rd_mon ? 8'h00 : mon_fail_sticky) | stat.mon_fail;
        next_ref_fail = (rd_ref ? 8'h00 : ref_fail_sticky)
            | (stat.ref_fail & ~mon_fail_mask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loop_events <= 8'h00;
            mon_fail_sticky <= 8'h00;
            ref_fail_sticky <= 8'h00;
        end else begin
            loop_events <= next_loop_events;
            mon_fail_sticky <= next_mon_fail;
            ref_fail_sticky <= next_ref_fail;
        end
    end

    // interrupt output
    always_ff @(posedge clk) begin
        if (reset) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~(|(ref_fail_sticky & ~ref_fail_mask)
                | |(loop_events & ~loop_mask));
        end
    end

    // writable control registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_fail_mask <= csrb_pkg::MASK_RESET;
            loop_mask <= csrb_pkg::MASK_RESET;
            mon_fail_mask <= csrb_pkg::MASK_RESET;
            loop_bandwidth <= csrb_pkg::LOOP_BW_RESET;
            holdover_trigger_mask <= csrb_pkg::HOLDOVER_MASK_RESET;
        end else if (req.wr) begin
            unique case (req.addr)
                csrb_pkg::ADDR_REF_FAIL_EVENT_MASK: ref_fail_mask <= req.wdata;
                csrb_pkg::ADDR_LOOP_EVENT_MASK: loop_mask <= req.wdata;
                csrb_pkg::ADDR_REF_MON_FAIL_MASK: mon_fail_mask <= req.wdata;
                csrb_pkg::ADDR_LOOP_BW: loop_bandwidth <= req.wdata;
                csrb_pkg::ADDR_HOLDOVER_MASK: holdover_trigger_mask <= req.wdata;
                default: ;
            endcase
        end
    end

    // automatic holdover request from unmasked failure indicators
    always_ff @(posedge clk) begin
        if (reset) begin
            holdover_trigger <= 1'b0;
        end else begin
            holdover_trigger <= |(stat.mon_fail & ~holdover_trigger_mask);
        end
    end

    // multi-byte phase offset write path
    always_ff @(posedge clk) begin
        if (reset) begin
            wbuf_low <= 8'h00;
            wbuf_mid <= 8'h00;
            frame_phase_offset <= csrb_pkg::PHASE_RESET;
        end else if (req.wr) begin
            if (req.addr == csrb_pkg::ADDR_PHASE_LOW) begin
                wbuf_low <= req.wdata;
            end
            if (req.addr == csrb_pkg::ADDR_PHASE_MID) begin
                wbuf_mid <= req.wdata;
            end
            if (req.addr == csrb_pkg::ADDR_PHASE_HIGH) begin
                frame_phase_offset <= {req.wdata[csrb_pkg::PHASE_HIGH_BITS-1:0],
                    wbuf_mid, wbuf_low};
            end
        end
    end

    // multi-byte read snapshot taken at low byte read
    always_ff @(posedge clk) begin
        if (reset) begin
            rsnap <= csrb_pkg::PHASE_RESET;
        end else if (req.rd && req.addr == csrb_pkg::ADDR_PHASE_LOW) begin
            rsnap <= frame_phase_offset;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 8'h00;
        unique case (req.addr)
            csrb_pkg::ADDR_CHIP_ID: next_rdata = csrb_pkg::CHIP_ID_VALUE;
            csrb_pkg::ADDR_REF_FAIL_EVENT: next_rdata = ref_fail_sticky;
            csrb_pkg::ADDR_LOOP_EVENT: next_rdata = loop_events;
            csrb_pkg::ADDR_REF_MON_FAIL: next_rdata = mon_fail_sticky;
            csrb_pkg::ADDR_REF_FAIL_EVENT_MASK: next_rdata = ref_fail_mask;
            csrb_pkg::ADDR_LOOP_EVENT_MASK: next_rdata = loop_mask;
            csrb_pkg::ADDR_REF_MON_FAIL_MASK: next_rdata = mon_fail_mask;
            csrb_pkg::ADDR_DETECTED_FREQ: next_rdata = stat.detected_freq;
            csrb_pkg::ADDR_LOOP_BW: next_rdata = loop_bandwidth;
            csrb_pkg::ADDR_HOLDOVER_MASK: next_rdata = holdover_trigger_mask;
            csrb_pkg::ADDR_LOCK_STATUS: begin
                next_rdata[csrb_pkg::LOCK_BIT] = stat.locked;
                next_rdata[csrb_pkg::HOLDOVER_BIT] = stat.holdover;
            end
            csrb_pkg::ADDR_PHASE_LOW: next_rdata = frame_phase_offset[7:0];
            csrb_pkg::ADDR_PHASE_MID: next_rdata = rsnap[15:8];
            csrb_pkg::ADDR_PHASE_HIGH: next_rdata = {2'h0, rsnap[21:16]};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end

    // assertions
    property p_int_follows;
        @(posedge clk) disable iff (reset)
        (|(loop_events & ~loop_mask)) |=> !int_n;
    endproperty
    a_int_follows: assert property (p_int_follows) else $error("int_n not asserted");

    property p_int_idle;
        @(posedge clk) disable iff (reset)
        (!(|(ref_fail_sticky & ~ref_fail_mask)) && !(|(loop_events & ~loop_mask))) |=> int_n;
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("int_n low with no event");

    property p_lock_event;
        @(posedge clk) disable iff (reset)
        (stat.locked != locked_d) |=> loop_events[csrb_pkg::LOOP_EV_LOCK];
    endproperty
    a_lock_event: assert property (p_lock_event) else $error("lock change not captured");

    property p_sticky_hold;
        @(posedge clk) disable iff (reset)
        (loop_events[csrb_pkg::LOOP_EV_HOLDOVER] && !rd_loop)
            |=> loop_events[csrb_pkg::LOOP_EV_HOLDOVER];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit lost");

    property p_read_clear;
        @(posedge clk) disable iff (reset)
        (rd_mon && stat.mon_fail == 8'h00) |=> mon_fail_sticky == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("sticky not cleared on read");

    property p_commit_high;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr != csrb_pkg::ADDR_PHASE_HIGH) |=> $stable(frame_phase_offset);
    endproperty
    a_commit_high: assert property (p_commit_high) else $error("offset changed early");

    property p_snap_stable;
        @(posedge clk) disable iff (reset)
        !(req.rd && req.addr == csrb_pkg::ADDR_PHASE_LOW) |=> $stable(rsnap);
    endproperty
    a_snap_stable: assert property (p_snap_stable) else $error("snapshot moved");

    property p_id_read;
        @(posedge clk) disable iff (reset)
        (req.rd && req.addr == csrb_pkg::ADDR_CHIP_ID) |=> rdata == csrb_pkg::CHIP_ID_VALUE;
    endproperty
    a_id_read: assert property (p_id_read) else $error("bad id read");

    property p_reserved_zero;
        @(posedge clk) disable iff (reset)
        (req.rd && req.addr == 7'h01) |=> rdata == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero");

    property p_int_ref;
        @(posedge clk) disable iff (reset)
        (|(ref_fail_sticky & ~ref_fail_mask)) |=> !int_n;
    endproperty
    a_int_ref: assert property (p_int_ref) else $error("int_n not asserted for ref");

    property p_ref_event;
        @(posedge clk) disable iff (reset)
        (stat.ref_fail[0] && !mon_fail_mask[0]) |=> ref_fail_sticky[0];
    endproperty
    a_ref_event: assert property (p_ref_event) else $error("ref failure not captured");

    property p_hold_event;
        @(posedge clk) disable iff (reset)
        (stat.holdover != holdover_d) |=> loop_events[csrb_pkg::LOOP_EV_HOLDOVER];
    endproperty
    a_hold_event: assert property (p_hold_event) else $error("holdover change lost");

    property p_ref_hold;
        @(posedge clk) disable iff (reset)
        (ref_fail_sticky[0] && !rd_ref) |=> ref_fail_sticky[0];
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("ref sticky bit lost");

    property p_mon_sticky;
        @(posedge clk) disable iff (reset)
        stat.mon_fail[1] |=> mon_fail_sticky[1];
    endproperty
    a_mon_sticky: assert property (p_mon_sticky) else $error("monitor failure lost");

    property p_loop_clear;
        @(posedge clk) disable iff (reset)
        (rd_loop && stat.locked == locked_d && stat.holdover == holdover_d)
            |=> loop_events == 8'h00;
    endproperty
    a_loop_clear: assert property (p_loop_clear) else $error("loop events not cleared");

    property p_ref_clear;
        @(posedge clk) disable iff (reset)
        (rd_ref && stat.ref_fail == 8'h00) |=> ref_fail_sticky == 8'h00;
    endproperty
    a_ref_clear: assert property (p_ref_clear) else $error("ref sticky not cleared");

    property p_rdata_hold;
        @(posedge clk) disable iff (reset)
        !req.rd |=> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved without read");

    property p_offset_commit;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr == csrb_pkg::ADDR_PHASE_HIGH)
            |=> frame_phase_offset[15:0] == {$past(wbuf_mid), $past(wbuf_low)};
    endproperty
    a_offset_commit: assert property (p_offset_commit) else $error("offset bytes wrong");

    property p_offset_high;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr == csrb_pkg::ADDR_PHASE_HIGH)
            |=> {2'h0, frame_phase_offset[21:16]} == ($past(req.wdata) & 8'h3F);
    endproperty
    a_offset_high: assert property (p_offset_high) else $error("offset msb wrong");

    property p_snap_take;
        @(posedge clk) disable iff (reset)
        (req.rd && req.addr == csrb_pkg::ADDR_PHASE_LOW)
            |=> rsnap == $past(frame_phase_offset);
    endproperty
    a_snap_take: assert property (p_snap_take) else $error("snapshot not taken");

    property p_freq_read;
        @(posedge clk) disable iff (reset)
        (req.rd && req.addr == csrb_pkg::ADDR_DETECTED_FREQ)
            |=> rdata == $past(stat.detected_freq);
    endproperty
    a_freq_read: assert property (p_freq_read) else $error("bad frequency read");

    property p_lock_read;
        @(posedge clk) disable iff (reset)
        (req.rd && req.addr == csrb_pkg::ADDR_LOCK_STATUS)
            |=> rdata[csrb_pkg::LOCK_BIT] == $past(stat.locked);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("bad lock status read");

    property p_bw_write;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr == csrb_pkg::ADDR_LOOP_BW) |=> loop_bandwidth == $past(req.wdata);
    endproperty
    a_bw_write: assert property (p_bw_write) else $error("bandwidth not written");

    property p_mask_write;
        @(posedge clk) disable iff (reset)
        (req.wr && req.addr == csrb_pkg::ADDR_LOOP_EVENT_MASK)
            |=> loop_mask == $past(req.wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("loop mask not written");

    property p_trig_set;
        @(posedge clk) disable iff (reset)
        (|(stat.mon_fail & ~holdover_trigger_mask)) |=> holdover_trigger;
    endproperty
    a_trig_set: assert property (p_trig_set) else $error("holdover not requested");

    property p_trig_quiet;
        @(posedge clk) disable iff (reset)
        ((stat.mon_fail & ~holdover_trigger_mask) == 8'h00) |=> !holdover_trigger;
    endproperty
    a_trig_quiet: assert property (p_trig_quiet) else $error("stray holdover request");
endmodule // csrb_bank

// [rtl/csrb_pkg.sv]
/*
 register bank package: offsets, field positions, reset values and carriers.
 assumes a byte-wide register port driven by a serial front end.
*/
package csrb_pkg;
    localparam logic [6:0] ADDR_CHIP_ID = 7'h00;
    localparam logic [6:0] ADDR_REF_FAIL_EVENT = 7'h02;
    localparam logic [6:0] ADDR_LOOP_EVENT = 7'h03;
    localparam logic [6:0] ADDR_REF_MON_FAIL = 7'h05;
    localparam logic [6:0] ADDR_REF_FAIL_EVENT_MASK = 7'h09;
    localparam logic [6:0] ADDR_LOOP_EVENT_MASK = 7'h0A;
    localparam logic [6:0] ADDR_REF_MON_FAIL_MASK = 7'h0C;
    localparam logic [6:0] ADDR_DETECTED_FREQ = 7'h10;
    localparam logic [6:0] ADDR_LOOP_BW = 7'h1D;
    localparam logic [6:0] ADDR_HOLDOVER_MASK = 7'h21;
    localparam logic [6:0] ADDR_LOCK_STATUS = 7'h28;
    localparam logic [6:0] ADDR_PHASE_LOW = 7'h40;
    localparam logic [6:0] ADDR_PHASE_MID = 7'h41;
    localparam logic [6:0] ADDR_PHASE_HIGH = 7'h42;
    // arbitrary identification value
    localparam logic [7:0] CHIP_ID_VALUE = 8'h5A;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [7:0] LOOP_BW_RESET = 8'h00;
    localparam logic [7:0] HOLDOVER_MASK_RESET = 8'h00;
    localparam logic [21:0] PHASE_RESET = 22'h000000;
    localparam int PHASE_HIGH_BITS = 6;
    // loop event bit positions
    localparam int LOOP_EV_LOCK = 0;
    localparam int LOOP_EV_HOLDOVER = 1;
    // lock status bit positions
    localparam int LOCK_BIT = 0;
    localparam int HOLDOVER_BIT = 1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } csrb_req_t;

    typedef struct packed {
        logic [7:0] ref_fail;
        logic [7:0] mon_fail;
        logic [7:0] detected_freq;
        logic locked;
        logic holdover;
    } csrb_stat_t;
endpackage

// [sim/csrb_host.sv]
/*
 host model: single-byte register reads and writes, multi-byte offset write.
 assumes the bank samples its request on the rising clock edge.
*/
`timescale 1ns/1ns
module csrb_host (
    input wire logic clk,
    output csrb_pkg::csrb_req_t req
);
    initial req = '0;
    // one byte access, strobe for one cycle, lines inverted when idle
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge clk);
        req = {w, ~w, a, d};
        @(negedge clk);
        req = {2'h0, ~a, ~d};
    endtask
    // offset write, low byte first and high byte last
    task automatic write_offset(input logic [21:0] v);
        access(1'h1, 7'h40, v[7:0]);
        access(1'h1, 7'h41, v[15:8]);
        access(1'h1, 7'h42, {2'h0, v[21:16]});
    endtask
endmodule // csrb_host

// [sim/tb_clock_sync_register_bank_irq.sv]
/*
 testbench of the register bank: host model drives, a monitor checks reads.
 assumes rdata is settled one cycle after the read strobe is taken.
*/
`timescale 1ns/1ns
module tb_clock_sync_register_bank_irq;
    logic clk;
    logic reset;
    csrb_pkg::csrb_req_t req;
    csrb_pkg::csrb_stat_t stat;
    logic [7:0] rdata;
    logic int_n;
    logic [7:0] bw;
    logic [7:0] hmask;
    logic htrig;
    logic [21:0] fpo;
    logic [7:0] exp_q[$];
    logic [1:0] rd_pipe = 2'h0;
    logic [31:0] seed;
    logic [21:0] v;
    logic [7:0] b;
    logic [7:0] c;
    logic [6:0] rw_a[5] = '{7'h09, 7'h0A, 7'h0C, 7'h1D, 7'h21};
    logic [7:0] rw_r[5] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
    int miscompares;
    int compares;
    csrb_bank csrb_bank_i (.clk(clk), .reset(reset), .req(req), .stat(stat), .rdata(rdata),
        .int_n(int_n), .loop_bandwidth(bw), .holdover_trigger_mask(hmask),
        .holdover_trigger(htrig), .frame_phase_offset(fpo));
    csrb_host csrb_host_i (.clk(clk), .req(req));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (exp_q.size() != 0) miscompares++;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        csrb_host_i.access(1'h0, a, 8'h00);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        csrb_host_i.access(1'h1, a, d);
    endtask
    // read result monitor
    always @(posedge clk) rd_pipe <= {rd_pipe[0], req.rd};
    always @(negedge clk) begin
        if (rd_pipe[1] === 1'h1) begin
            if (exp_q.size() == 0) compare(32'h1, 32'h0);
            else compare({24'h0, rdata}, {24'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        reset = 1'h1;
        stat = '0;
        seed = 32'h6617;
        miscompares = 0;
        compares = 0;
        repeat (10) @(posedge clk);
        @(negedge clk) reset = 1'h0;
        stat.detected_freq = 8'(rnd());
        compare({31'h0, int_n}, 32'h1);
        rd(7'h00, csrb_pkg::CHIP_ID_VALUE);
        wr(7'h00, 8'hA5);
        rd(7'h00, csrb_pkg::CHIP_ID_VALUE);
        wr(7'h01, 8'hFF);
        rd(7'h01, 8'h00);
        rd(7'h7F, 8'h00);
        rd(7'h10, stat.detected_freq);
        foreach (rw_a[i]) begin
            b = 8'(rnd());
            rd(rw_a[i], rw_r[i]);
            wr(rw_a[i], b);
            rd(rw_a[i], b);
            if (i == 3) compare({24'h0, bw}, {24'h0, b});
            if (i == 4) compare({24'h0, hmask}, {24'h0, b});
            wr(rw_a[i], 8'h00);
        end
        b = 8'(rnd()) | 8'h01;
        c = 8'(rnd()) | 8'h02;
        stat.ref_fail = b;
        stat.mon_fail = c;
        repeat (2) @(negedge clk);
        compare({31'h0, htrig}, 32'h1);
        compare({31'h0, int_n}, 32'h0);
        stat.ref_fail = 8'h00;
        stat.mon_fail = 8'h00;
        rd(7'h02, b);
        rd(7'h05, c);
        rd(7'h02, 8'h00);
        rd(7'h05, 8'h00);
        compare({31'h0, int_n}, 32'h1);
        wr(7'h21, 8'hFF);
        wr(7'h09, 8'hFF);
        stat.mon_fail = c;
        stat.ref_fail = b;
        repeat (3) @(negedge clk);
        compare({31'h0, htrig}, 32'h0);
        compare({31'h0, int_n}, 32'h1);
        stat.ref_fail = 8'h00;
        rd(7'h02, b);
        wr(7'h0C, 8'hFF);
        stat.ref_fail = b;
        repeat (2) @(negedge clk);
        stat.ref_fail = 8'h00;
        rd(7'h02, 8'h00);
        wr(7'h0C, 8'h00);
        wr(7'h09, 8'h00);
        stat.locked = 1'h1;
        repeat (2) @(negedge clk);
        compare({31'h0, int_n}, 32'h0);
        rd(7'h28, 8'h01);
        rd(7'h03, 8'h01);
        rd(7'h03, 8'h00);
        stat.locked = 1'h0;
        stat.holdover = 1'h1;
        rd(7'h28, 8'h02);
        compare({31'h0, int_n}, 32'h0);
        rd(7'h03, 8'h03);
        @(negedge clk);
        compare({31'h0, int_n}, 32'h1);
        v = 22'(rnd());
        wr(7'h40, v[7:0]);
        wr(7'h41, v[15:8]);
        compare({10'h0, fpo}, {10'h0, csrb_pkg::PHASE_RESET});
        wr(7'h42, {2'h0, v[21:16]});
        compare({10'h0, fpo}, {10'h0, v});
        rd(7'h40, v[7:0]);
        csrb_host_i.write_offset(~v);
        rd(7'h41, v[15:8]);
        rd(7'h42, {2'h0, v[21:16]});
        compare({10'h0, fpo}, {10'h0, ~v});
        repeat (3) @(negedge clk);
        complete_run();
    end
endmodule // tb_clock_sync_register_bank_irq
